//--- sdcs_pkg.sv
// Package: shared constants and carrier types for the SDRAM sequencer
package sdcs_pkg;
    // Command on cs_n, ras_n, cas_n, we_n
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdcs_cmd_t;
    localparam sdcs_cmd_t CMD_MRS = 4'h0;
    localparam sdcs_cmd_t CMD_REF = 4'h1;
    localparam sdcs_cmd_t CMD_PRE = 4'h2;
    localparam sdcs_cmd_t CMD_ACT = 4'h3;
    localparam sdcs_cmd_t CMD_WR = 4'h4;
    localparam sdcs_cmd_t CMD_RD = 4'h5;
    localparam sdcs_cmd_t CMD_DESELECT_CMD = 4'hF;
    // Access request from the user side
    typedef struct packed {
        logic write;
        logic [1:0] bank;
        logic [12:0] row;
        logic [12:0] col;
    } sdcs_req_t;
    // Register offsets (byte addresses, aliased every 20h)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_REFI = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    // Control fields
    localparam int CTRL_CL_LSB = 0;
    localparam int CTRL_REFEN_BIT = 3;
    localparam int CTRL_SR_BIT = 4;
    localparam int CTRL_DIV_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000040A;
    // Mode register fields
    localparam logic [2:0] MRS_BURST_LEN = 3'h1;
    localparam logic MRS_BURST_ILV = 1'b1;
    localparam int A10_BIT = 10;
    localparam logic [3:0] INIT_REFS = 4'h8;
    // Timing
    localparam int CLK_NS = 10;
    localparam int REF_PERIOD_NS = 15000;
    localparam int REF_CYCLES = REF_PERIOD_NS / CLK_NS;
    localparam logic [31:0] REFI_RST = 32'(REF_CYCLES);
    localparam int POWERUP_NS = 100000;
    localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CMD_GAP_TICKS = 3;
    // Sequencer states
    typedef enum logic [7:0] {
        ST_POWER = 8'h01,
        ST_INIT_PRE = 8'h02,
        ST_INIT_REF1 = 8'h04,
        ST_INIT_MRS = 8'h08,
        ST_INIT_REF2 = 8'h10,
        ST_IDLE = 8'h20,
        ST_REFRESH = 8'h40,
        ST_SELF = 8'h80
    } sdcs_state_t;
endpackage

//--- sdcs_sequencer.sv
// SDRAM command sequencer with Avalon-MM control registers
`timescale 1ns/1ps
// Behaviour
// - Commands coded on cs, ras, cas, we, active low; deselect raises cs.
// - Refresh code with clock enable low enters self refresh.
// - Mode set puts burst length, type, CAS latency on address bits.
// - Burst is always two beats, interleaved.
// - Mode set drives bank lines and address bits 12..7 to zero.
// - CAS latency 1 to 7 clocks; code zero is never programmed.
// - Precharge bit 10 picks one bank or all; bank lines name it.
// - A precharged bank is activated before any read or write.
// - Activate carries bank and row; row stays open until precharged.
// - Write carries bank and column, no auto precharge.
// - Write lanes with mask high are not stored.
// - Read has no auto precharge; data captured after CAS latency.
// - Masks stay low during reads.
// - All banks are precharged before each auto refresh.
// - Auto refresh about every fifteen microseconds.
// - Suspend issues self refresh with clock enable low.
// - Init: precharge all, eight refreshes, mode set, eight refreshes.
// - Registers decode a 100h span and alias inside it.
// - Memory clock is the core clock divided by 2 to 5.
module sdcs_sequencer #(
    parameter int DW = 64,
    parameter int POWERUP_CYC = sdcs_pkg::POWERUP_CYCLES,
    parameter int GAP = sdcs_pkg::CMD_GAP_TICKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // User access port
    input wire logic req_valid,
    input wire sdcs_pkg::sdcs_req_t req,
    input wire logic [2*DW-1:0] req_wdata,
    input wire logic [2*DW/8-1:0] req_mask,
    output logic req_ready,
    output logic [2*DW-1:0] rd_data,
    output logic rd_valid,
    // SDRAM pins
    output logic sdclk,
    output logic mem_cke,
    output sdcs_pkg::sdcs_cmd_t mem_cmd,
    output logic [1:0] mem_ba,
    output logic [12:0] mem_addr_bus,
    output logic [DW/8-1:0] mem_dqm,
    output logic [DW-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe_n,
    input wire logic [DW-1:0] mem_data_bus_in
);
    localparam int MW = DW / 8;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] ctrl_reg, refi_reg;
    logic [15:0] pwr_reg, ref_tmr_reg;
    logic [3:0] div_reg;
    logic ref_due_reg, init_done_reg;
    sdcs_pkg::sdcs_state_t state_reg, state_next;
    sdcs_pkg::sdcs_cmd_t cmd_next;
    logic cke_next;
    logic [1:0] ba_next;
    logic [12:0] addr_next;
    logic [3:0] gap_reg, gap_next, icnt_reg, icnt_next;
    logic [3:0] vld_reg, vld_next;
    logic [3:0][12:0] row_reg, row_next;
    logic [2:0] rd_cnt_reg, rd_cnt_next;
    logic rd_beat_reg, rd_beat_next, wr_beat_reg, wr_beat_next;
    logic [DW-1:0] wr_hi_reg, wr_hi_next, dq_next;
    logic [MW-1:0] mhi_reg, mhi_next, dqm_next;
    logic oe_n_next, ready_next, rdv_next, ref_clr;
    logic [2*DW-1:0] rdd_next;

    // Register decode, aliased over the 100h span
    wire bus_req = avs_read | avs_write;
    wire bus_go = bus_req & ~avs_waitrequest;
    wire [2:0] word = avs_address[4:2];
    wire sel_ctrl = word == sdcs_pkg::REG_CTRL[4:2];
    wire sel_refi = word == sdcs_pkg::REG_REFI[4:2];
    wire sel_stat = word == sdcs_pkg::REG_STAT[4:2];
    wire [31:0] ctrl_wr = merge(ctrl_reg, avs_writedata, avs_byteenable);
    wire [31:0] stat_val = {24'h0, vld_reg, 1'b0, ref_due_reg,
        ~mem_cke, init_done_reg};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_reg : sel_refi ? refi_reg :
        sel_stat ? stat_val : 32'h0;
    wire [2:0] cas = ctrl_reg[sdcs_pkg::CTRL_CL_LSB +: 3];
    wire cas_ok = ctrl_wr[sdcs_pkg::CTRL_CL_LSB +: 3] != 3'h0;
    wire ref_en = ctrl_reg[sdcs_pkg::CTRL_REFEN_BIT];
    wire sr_req = ctrl_reg[sdcs_pkg::CTRL_SR_BIT];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            ctrl_reg <= sdcs_pkg::CTRL_RST;
            refi_reg <= sdcs_pkg::REFI_RST;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
            if (bus_go && avs_write && sel_ctrl && cas_ok) begin
                ctrl_reg <= ctrl_wr;
            end
            if (bus_go && avs_write && sel_refi) begin
                refi_reg <= merge(refi_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // Memory clock divider: ratio in half steps, rounded up to whole cycles
    wire [3:0] div_half = ctrl_reg[sdcs_pkg::CTRL_DIV_LSB +: 4];
    wire [3:0] per = (div_half < 4'h4) ? 4'h2 : (div_half > 4'hA) ? 4'h5 :
        4'((div_half + 4'h1) >> 1);
    wire [3:0] div_next = (div_reg >= per - 4'h1) ? 4'h0 : div_reg + 4'h1;
    wire sd_tick = div_next == (per >> 1);

    // Refresh pacing; a new due wins over its clear
    wire ref_hit = ref_tmr_reg >= refi_reg[15:0];
    wire pwr_done = pwr_reg == 16'(POWERUP_CYC);
    wire hit = vld_reg[req.bank] && row_reg[req.bank] == req.row;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 4'h0;
            sdclk <= 1'b1;
            ref_tmr_reg <= 16'h0;
            ref_due_reg <= 1'b0;
            pwr_reg <= 16'h0;
        end else begin
            div_reg <= div_next;
            sdclk <= div_next < (per >> 1);
            ref_tmr_reg <= ref_hit ? 16'h0 : ref_tmr_reg + 16'h1;
            ref_due_reg <= (ref_hit & ref_en) | (ref_due_reg & ~ref_clr);
            pwr_reg <= pwr_done ? pwr_reg : pwr_reg + 16'h1;
        end
    end

    always_comb begin
        state_next = state_reg;
        cmd_next = mem_cmd;
        cke_next = mem_cke;
        ba_next = mem_ba;
        addr_next = mem_addr_bus;
        gap_next = gap_reg;
        icnt_next = icnt_reg;
        vld_next = vld_reg;
        row_next = row_reg;
        rd_cnt_next = rd_cnt_reg;
        rd_beat_next = rd_beat_reg;
        wr_beat_next = wr_beat_reg;
        wr_hi_next = wr_hi_reg;
        mhi_next = mhi_reg;
        dq_next = mem_data_bus_out;
        dqm_next = mem_dqm;
        oe_n_next = mem_data_bus_oe_n;
        rdd_next = rd_data;
        ready_next = 1'b0;
        rdv_next = 1'b0;
        ref_clr = 1'b0;
        if (sd_tick) begin
            cmd_next = sdcs_pkg::CMD_DESELECT_CMD;
            // Second write beat, then release the data bus
            if (wr_beat_reg) begin
                dq_next = wr_hi_reg;
                dqm_next = mhi_reg;
                wr_beat_next = 1'b0;
            end else begin
                oe_n_next = 1'b1;
                dqm_next = '0;
            end
            // Capture read beats at the CAS latency
            if (rd_cnt_reg != 3'h0) begin
                rd_cnt_next = rd_cnt_reg - 3'h1;
                if (rd_cnt_reg == 3'h1) begin
                    rdd_next[DW-1:0] = mem_data_bus_in;
                    rd_beat_next = 1'b1;
                end
            end
            if (rd_beat_reg) begin
                rdd_next[2*DW-1:DW] = mem_data_bus_in;
                rd_beat_next = 1'b0;
                rdv_next = 1'b1;
            end
            if (gap_reg != 4'h0) begin
                gap_next = gap_reg - 4'h1;
            end else begin
                unique case (state_reg)
                    sdcs_pkg::ST_POWER: begin
                        if (pwr_done) begin
                            state_next = sdcs_pkg::ST_INIT_PRE;
                        end
                    end
                    sdcs_pkg::ST_INIT_PRE: begin
                        cmd_next = sdcs_pkg::CMD_PRE;
                        addr_next[sdcs_pkg::A10_BIT] = 1'b1;
                        icnt_next = sdcs_pkg::INIT_REFS;
                        gap_next = 4'(GAP);
                        state_next = sdcs_pkg::ST_INIT_REF1;
                    end
                    sdcs_pkg::ST_INIT_REF1, sdcs_pkg::ST_INIT_REF2: begin
                        cmd_next = sdcs_pkg::CMD_REF;
                        icnt_next = icnt_reg - 4'h1;
                        gap_next = 4'(GAP);
                        ref_clr = 1'b1;
                        if (icnt_reg == 4'h1) begin
                            state_next =
                                (state_reg == sdcs_pkg::ST_INIT_REF1) ?
                                sdcs_pkg::ST_INIT_MRS : sdcs_pkg::ST_IDLE;
                        end
                    end
                    sdcs_pkg::ST_INIT_MRS: begin
                        cmd_next = sdcs_pkg::CMD_MRS;
                        ba_next = 2'h0;
                        addr_next = {6'h0, cas, sdcs_pkg::MRS_BURST_ILV,
                            sdcs_pkg::MRS_BURST_LEN};
                        icnt_next = sdcs_pkg::INIT_REFS;
                        gap_next = 4'(GAP);
                        state_next = sdcs_pkg::ST_INIT_REF2;
                    end
                    sdcs_pkg::ST_IDLE: begin
                        if (sr_req || ref_due_reg) begin
                            cmd_next = sdcs_pkg::CMD_PRE;
                            addr_next[sdcs_pkg::A10_BIT] = 1'b1;
                            vld_next = 4'h0;
                            gap_next = 4'(GAP);
                            state_next = sdcs_pkg::ST_REFRESH;
                        end else if (req_valid && hit) begin
                            cmd_next = req.write ? sdcs_pkg::CMD_WR :
                                sdcs_pkg::CMD_RD;
                            ba_next = req.bank;
                            addr_next = req.col;
                            addr_next[sdcs_pkg::A10_BIT] = 1'b0;
                            ready_next = 1'b1;
                            if (req.write) begin
                                dq_next = req_wdata[DW-1:0];
                                dqm_next = req_mask[MW-1:0];
                                oe_n_next = 1'b0;
                                wr_hi_next = req_wdata[2*DW-1:DW];
                                mhi_next = req_mask[2*MW-1:MW];
                                wr_beat_next = 1'b1;
                                gap_next = 4'(GAP);
                            end else begin
                                rd_cnt_next = cas;
                                gap_next = 4'({1'b0, cas} + 4'h2);
                            end
                        end else if (req_valid && vld_reg[req.bank]) begin
                            cmd_next = sdcs_pkg::CMD_PRE;
                            ba_next = req.bank;
                            addr_next[sdcs_pkg::A10_BIT] = 1'b0;
                            vld_next[req.bank] = 1'b0;
                            gap_next = 4'(GAP);
                        end else if (req_valid) begin
                            cmd_next = sdcs_pkg::CMD_ACT;
                            ba_next = req.bank;
                            addr_next = req.row;
                            vld_next[req.bank] = 1'b1;
                            row_next[req.bank] = req.row;
                            gap_next = 4'(GAP);
                        end
                    end
                    sdcs_pkg::ST_REFRESH: begin
                        cmd_next = sdcs_pkg::CMD_REF;
                        cke_next = ~sr_req;
                        ref_clr = 1'b1;
                        gap_next = 4'(GAP);
                        state_next = sr_req ? sdcs_pkg::ST_SELF :
                            sdcs_pkg::ST_IDLE;
                    end
                    sdcs_pkg::ST_SELF: begin
                        if (!sr_req) begin
                            cke_next = 1'b1;
                            gap_next = 4'(GAP);
                            state_next = sdcs_pkg::ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= sdcs_pkg::ST_POWER;
            mem_cmd <= sdcs_pkg::CMD_DESELECT_CMD;
            mem_cke <= 1'b1;
            mem_ba <= 2'h0;
            mem_addr_bus <= 13'h0;
            gap_reg <= 4'h0;
            icnt_reg <= 4'h0;
            vld_reg <= 4'h0;
            row_reg <= '0;
            init_done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mem_cmd <= cmd_next;
            mem_cke <= cke_next;
            mem_ba <= ba_next;
            mem_addr_bus <= addr_next;
            gap_reg <= gap_next;
            icnt_reg <= icnt_next;
            vld_reg <= vld_next;
            row_reg <= row_next;
            init_done_reg <= init_done_reg | (state_next == sdcs_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_cnt_reg <= 3'h0;
            rd_beat_reg <= 1'b0;
            wr_beat_reg <= 1'b0;
            wr_hi_reg <= '0;
            mhi_reg <= '0;
            mem_data_bus_out <= '0;
            mem_dqm <= '0;
            mem_data_bus_oe_n <= 1'b1;
            rd_data <= '0;
            rd_valid <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            rd_cnt_reg <= rd_cnt_next;
            rd_beat_reg <= rd_beat_next;
            wr_beat_reg <= wr_beat_next;
            wr_hi_reg <= wr_hi_next;
            mhi_reg <= mhi_next;
            mem_data_bus_out <= dq_next;
            mem_dqm <= dqm_next;
            mem_data_bus_oe_n <= oe_n_next;
            rd_data <= rdd_next;
            rd_valid <= rdv_next;
            req_ready <= ready_next;
        end
    end

    // Checks
    wire last_ok = (mem_cmd == sdcs_pkg::CMD_REF) ||
        (mem_cmd == sdcs_pkg::CMD_MRS) ||
        (mem_cmd == sdcs_pkg::CMD_PRE && mem_addr_bus[sdcs_pkg::A10_BIT]);
    logic prev_ok_reg;
    logic [15:0] since_ref_reg;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev_ok_reg <= 1'b0;
            since_ref_reg <= 16'h0;
        end else begin
            if (mem_cmd != sdcs_pkg::CMD_DESELECT_CMD) begin
                prev_ok_reg <= last_ok;
            end
            since_ref_reg <= (mem_cmd == sdcs_pkg::CMD_REF ||
                state_reg != sdcs_pkg::ST_IDLE || !ref_en) ?
                16'h0 : since_ref_reg + 16'h1;
        end
    end

    property p_mrs_addr;
        @(posedge clock) disable iff (!nrst)
        mem_cmd == sdcs_pkg::CMD_MRS |-> mem_ba == 2'h0 &&
            mem_addr_bus[12:7] == 6'h0 && mem_addr_bus[3:0] == 4'h9 &&
            mem_addr_bus[6:4] != 3'h0;
    endproperty
    a_mrs_addr: assert property (p_mrs_addr)
        else $error("mode set address wrong");
    property p_ref_after_pre;
        @(posedge clock) disable iff (!nrst)
        sd_tick && cmd_next == sdcs_pkg::CMD_REF |->
            (mem_cmd == sdcs_pkg::CMD_DESELECT_CMD) ? prev_ok_reg : last_ok;
    endproperty
    a_ref_after_pre: assert property (p_ref_after_pre)
        else $error("refresh without prior precharge all");
    property p_col_no_ap;
        @(posedge clock) disable iff (!nrst)
        (mem_cmd == sdcs_pkg::CMD_WR || mem_cmd == sdcs_pkg::CMD_RD) |->
            !mem_addr_bus[sdcs_pkg::A10_BIT] && vld_reg[mem_ba];
    endproperty
    a_col_no_ap: assert property (p_col_no_ap)
        else $error("column command with auto precharge or closed bank");
    property p_act_idle;
        @(posedge clock) disable iff (!nrst)
        sd_tick && cmd_next == sdcs_pkg::CMD_ACT |-> !vld_reg[ba_next];
    endproperty
    a_act_idle: assert property (p_act_idle)
        else $error("activate on an open bank");
    property p_rd_dqm;
        @(posedge clock) disable iff (!nrst)
        $rose(mem_cmd == sdcs_pkg::CMD_RD) |-> mem_dqm == '0 ##1
            (mem_dqm == '0) [*8];
    endproperty
    a_rd_dqm: assert property (p_rd_dqm)
        else $error("mask high during read");
    property p_cke_low;
        @(posedge clock) disable iff (!nrst)
        $fell(mem_cke) |-> mem_cmd == sdcs_pkg::CMD_REF &&
            state_reg == sdcs_pkg::ST_SELF;
    endproperty
    a_cke_low: assert property (p_cke_low)
        else $error("clock enable dropped without self refresh");
    property p_ref_pace;
        @(posedge clock) disable iff (!nrst)
        since_ref_reg <= refi_reg[15:0] + 16'd200;
    endproperty
    a_ref_pace: assert property (p_ref_pace)
        else $error("refresh overdue");
    property p_rd_capture;
        @(posedge clock) disable iff (!nrst)
        rd_valid |-> $past(rd_beat_reg) && !rd_beat_reg && rd_cnt_reg == 3'h0;
    endproperty
    a_rd_capture: assert property (p_rd_capture)
        else $error("read data valid out of step");
    property p_wait_one;
        @(posedge clock) disable iff (!nrst)
        bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer not one cycle");
    c_init: cover property (@(posedge clock) disable iff (!nrst)
        $rose(init_done_reg));
    c_write: cover property (@(posedge clock) disable iff (!nrst)
        mem_cmd == sdcs_pkg::CMD_WR);
    c_read: cover property (@(posedge clock) disable iff (!nrst) rd_valid);
    c_self: cover property (@(posedge clock) disable iff (!nrst)
        state_reg == sdcs_pkg::ST_SELF);
endmodule // sdcs_sequencer

//--- sdcs_sdram_model.sv
// Behavioural SDRAM that stores masked writes and returns bursts
`timescale 1ns/1ps
module sdcs_sdram_model (
    // SDRAM pins
    input wire logic sdclk,
    input wire sdcs_pkg::sdcs_cmd_t mem_cmd,
    input wire logic [1:0] mem_ba,
    input wire logic [12:0] mem_addr_bus,
    input wire logic [7:0] mem_dqm,
    input wire logic [63:0] mem_data_bus_out,
    input wire logic mem_data_bus_oe_n,
    output logic [63:0] mem_data_bus_in
);
    logic [63:0] mem [logic [27:0]];
    logic [12:0] rows [4];
    logic [27:0] wa, ra;
    int cl = 2, wk = 0, rk = 0;
    initial mem_data_bus_in = '0;
    always @(posedge sdclk) begin
        if (mem_cmd === sdcs_pkg::CMD_MRS) cl = mem_addr_bus[6:4];
        if (mem_cmd === sdcs_pkg::CMD_ACT)
            rows[mem_ba] = mem_addr_bus;
        if (mem_cmd === sdcs_pkg::CMD_WR) begin
            wa = {mem_ba, rows[mem_ba], mem_addr_bus};
            wk = 1;
        end
        if (wk > 0) begin
            if (!mem.exists(wa)) mem[wa] = '0;
            for (int i = 0; i < 8; i++) begin
                if (!mem_dqm[i] && !mem_data_bus_oe_n)
                    mem[wa][8*i+:8] = mem_data_bus_out[8*i+:8];
            end
            wa[0] = ~wa[0];
            wk = (wk == 1) ? 2 : 0;
        end
        if (mem_cmd === sdcs_pkg::CMD_RD) begin
            ra = {mem_ba, rows[mem_ba], mem_addr_bus};
            rk = 1;
        end else if (rk > 0) rk++;
        // Outside a burst the lines toggle so stale data never matches
        if (rk == cl || rk == cl + 1) begin
            mem_data_bus_in <= mem.exists(ra) ? mem[ra] : '0;
            ra[0] = ~ra[0];
        end else mem_data_bus_in <= ~mem_data_bus_in;
        if (rk == cl + 1) rk = 0;
    end
endmodule // sdcs_sdram_model

//--- testbench.sv
// Self-checking bench for the SDRAM command sequencer
`timescale 1ns/1ps
module testbench;
    logic clock = 0, nrst = 0, avs_read = 0, avs_write = 0, req_valid = 0;
    logic [7:0] avs_address = '0, mem_dqm;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic avs_waitrequest, req_ready, rd_valid, sdclk, mem_cke, oe_n;
    sdcs_pkg::sdcs_req_t req = '0;
    logic [127:0] req_wdata = '0, rd_data, ea, eb, ex;
    logic [15:0] req_mask = '0;
    sdcs_pkg::sdcs_cmd_t mem_cmd;
    logic [1:0] mem_ba;
    logic [12:0] mem_addr_bus;
    logic [63:0] dq_o, dq_i;
    logic sr_seen = 0;
    logic [27:0] lq [$];
    int fail_count = 0, n_checks = 0, cyc = 0, per = 0, last = 0;
    int ref_t [$];
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (mem_cmd === sdcs_pkg::CMD_REF && mem_cke === 1'b0) sr_seen = 1;
    end
    // Command log as the memory registers it
    always @(posedge sdclk) begin
        per = cyc - last;
        last = cyc;
        if (nrst && mem_cmd !== sdcs_pkg::CMD_DESELECT_CMD)
            lq.push_back({mem_dqm, mem_cke, mem_cmd, mem_ba, mem_addr_bus});
        if (mem_cmd === sdcs_pkg::CMD_REF) ref_t.push_back(cyc);
    end
    sdcs_sequencer #(.POWERUP_CYC(20)) dut_u (.clock(clock), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req(req),
        .req_wdata(req_wdata), .req_mask(req_mask), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .sdclk(sdclk),
        .mem_cke(mem_cke), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
        .mem_addr_bus(mem_addr_bus), .mem_dqm(mem_dqm),
        .mem_data_bus_out(dq_o), .mem_data_bus_oe_n(oe_n),
        .mem_data_bus_in(dq_i));
    sdcs_sdram_model mdl_u (.sdclk(sdclk), .mem_cmd(mem_cmd), .mem_ba(mem_ba),
        .mem_addr_bus(mem_addr_bus), .mem_dqm(mem_dqm),
        .mem_data_bus_out(dq_o), .mem_data_bus_oe_n(oe_n),
        .mem_data_bus_in(dq_i));
    task automatic check(input string nm, input logic [127:0] s, e);
        n_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic acc(input logic w, input logic [12:0] r,
        input logic [127:0] d, input logic [15:0] m);
        @(posedge clock);
        req <= '{w, 2'h1, r, 13'h0008};
        req_wdata <= d;
        req_mask <= m;
        req_valid <= 1;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 0;
        if (!w) do @(posedge clock); while (rd_valid !== 1'b1);
    endtask
    task automatic t_init;
        int n = 0;
        do bus(0, sdcs_pkg::REG_STAT, 0); while (q[0] !== 1'b1 && ++n < 300);
        check("sdclk_per", per, 2);
        check("init_len", lq.size(), 18);
        check("pre_all", {lq[0][18:15], lq[0][10]}, 5'h5);
        for (int i = 1; i < 18; i++)
            if (i != 9) check("init_ref", lq[i][18:15], 4'h1);
        check("mrs", lq[9][19:0], 20'h80029);
    endtask
    task automatic t_regs;
        bus(0, 8'h20, 0);
        check("ctrl_alias", q, sdcs_pkg::CTRL_RST);
        bus(0, sdcs_pkg::REG_REFI, 0);
        check("refi", q, sdcs_pkg::REFI_RST);
        bus(0, 8'h0C, 0);
        check("unmapped", q, 0);
        bus(1, sdcs_pkg::REG_CTRL, 32'h00000400);
        bus(0, sdcs_pkg::REG_CTRL, 0);
        check("cl_zero", q, sdcs_pkg::CTRL_RST);
        bus(1, sdcs_pkg::REG_CTRL, 32'h00000402);
    endtask
    task automatic t_rw;
        ea = {64'hA5A5A5A5A5A5A5A5, 64'h0123456789ABCDEF};
        eb = {64'hFEDCBA9876543210, 64'h5A5A5A5A5A5A5A5A};
        for (int i = 0; i < 16; i++)
            ex[8*i+:8] = (i < 4 || i > 11) ? ea[8*i+:8] : eb[8*i+:8];
        lq.delete();
        acc(1, 5, ea, 0);
        acc(1, 5, eb, 16'hF00F);
        acc(0, 5, 0, 0);
        check("masked_rd", rd_data, ex);
        check("act", lq[0][18:0], 19'h1A005);
        check("wr", lq[1][18:0], 19'h22008);
        check("wr_dqm", lq[2][27:15], 13'h01F4);
        check("rd", lq[3][27:0], 28'h00AA008);
    endtask
    task automatic t_miss;
        lq.delete();
        acc(0, 6, 0, 0);
        check("pre_one", {lq[0][18:13], lq[0][10]}, 7'h12);
        check("act_new", lq[1][18:0], 19'h1A006);
        check("rd_miss", lq[2][18:15], 4'h5);
        bus(0, sdcs_pkg::REG_STAT, 0);
        check("open_bank", q[7:4], 4'h2);
    endtask
    task automatic t_ref;
        int n = 0, k = 0;
        bus(1, sdcs_pkg::REG_REFI, 200);
        lq.delete();
        ref_t.delete();
        bus(1, sdcs_pkg::REG_CTRL, 32'h0000040A);
        do @(posedge clock); while (ref_t.size() < 2 && ++n < 2000);
        check("ref_gap", (ref_t[1] - ref_t[0]) inside {[200:240]}, 1);
        foreach (lq[i]) if (k == 0 && lq[i][18:15] === 4'h1) k = i;
        check("pre_ref", {lq[k-1][18:15], lq[k-1][10]}, 5'h5);
    endtask
    task automatic t_sr;
        int n = 0;
        bus(1, sdcs_pkg::REG_CTRL, 32'h0000041A);
        do bus(0, sdcs_pkg::REG_STAT, 0); while (q[1] !== 1'b1 && ++n < 300);
        check("self_ref", {sr_seen, mem_cke}, 2'h2);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1;
        t_init;
        t_regs;
        t_rw;
        t_miss;
        t_ref;
        t_sr;
        tally_and_finish;
    end
    initial begin
        repeat (40000) @(posedge clock);
        fail_count++;
        tally_and_finish;
    end
endmodule // testbench
